/* hdl/cmr_cfg.svh */
// Offsets, field positions and target addresses of the command block
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH

// Register word offsets
`define CMR_OFS_CMD 7'h01
`define CMR_OFS_RQ_WD 7'h03
`define CMR_OFS_RQ_DIAG0 7'h04
`define CMR_OFS_RQ_DIAGNOSIS_1 7'h05
`define CMR_RESET_VAL 8'h00

// Command field positions
`define CMR_B_WAKE_CLR 7
`define CMR_B_DOT_RST 6
`define CMR_B_EOT_START 5
`define CMR_B_UP_STOP 4
`define CMR_B_HB_SAMPLE 3
`define CMR_B_SENS_DIAG 2
`define CMR_B_MR_ON 1
`define CMR_B_MR_EN 0

// Target word addresses, request bit 7 down to 0
`define CMR_TGT_WD {7'h5f, 7'h63, 7'h36, 7'h2e, 7'h38, 7'h37, 7'h39, 7'h3a}
`define CMR_TGT_DIAG0 {7'h2a, 7'h21, 7'h33, 7'h32, 7'h31, 7'h24, 7'h23, 7'h22}
`define CMR_TGT_DIAGNOSIS_1 {7'h2d, 7'h2c, 7'h2b, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25}

`endif

/* hdl/cmr_pkg.sv */
// Types shared by the command and multi-read request block
package cmr_pkg;
  typedef enum logic [1:0] {
    CMR_IDLE = 2'b00,
    CMR_SEND = 2'b01,
    CMR_WAIT = 2'b10
  } cmr_state_t;
endpackage : cmr_pkg

/* hdl/cmr_pulse.sv */
// One-shot command pulse stage
`timescale 1ns/1ps
module cmr_pulse (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset
  input wire logic fire, // Write of a one
  output logic pulse // Registered one-cycle pulse
);
  // Pulse lasts one cycle; nothing is stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= fire;
    end
  end
endmodule : cmr_pulse

/* hdl/cmr_pick.sv */
// Highest-set-bit picker for a multi-read request mask
`timescale 1ns/1ps
module cmr_pick #(
  parameter int W = 8 // Mask width
) (
  input wire logic [W-1:0] mask, // Pending request bits
  output logic [$clog2(W)-1:0] idx, // Index of highest set bit
  output logic any // Some bit set
);
  // Scan upward so the highest bit wins, giving MSB-first order
  always_comb begin
    idx = '0;
    any = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (mask[i]) begin
        idx = i[$clog2(W)-1:0];
        any = 1'b1;
      end
    end
  end
endmodule : cmr_pick

/* hdl/cmr_regs.sv */
// Command register and multi-read request registers with burst sequencer
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "cmr_cfg.svh"

module cmr_regs
  import cmr_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic [6:0] addr, // Register word address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, one cycle after rd
  output logic wake_signal_clear, // Pulse
  output logic delayed_off_timer_restart, // Pulse
  output logic engine_off_timer_start, // Pulse
  output logic upstream_stop, // Pulse
  output logic heartbeat_timer_sample, // Pulse
  output logic sensor_diag_start, // Pulse
  output logic main_relay_state, // Main relay drive level
  input wire logic burst_ready, // Link takes a burst word
  output logic burst_valid, // Burst word offered
  output logic [6:0] burst_addr, // Target register address
  output logic burst_last, // Last word of the burst
  output logic burst_busy // Burst in progress
);

  // ------------------------------------------------------------
  // State held by the block
  // ------------------------------------------------------------
  // Declared up front, the decode below already reads them
  logic [7:0] pend_wd_reg, pend_d0_reg, pend_d1_reg;
  logic busy_reg;
  logic [1:0] grp_reg;
  cmr_state_t state_reg, state_next;
  logic [7:0] rdata_reg;
  logic valid_reg, last_reg;
  logic [6:0] baddr_reg;
  logic relay_reg;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire wr_cmd = wr && (addr == `CMR_OFS_CMD);
  wire wr_rq_wd = wr && (addr == `CMR_OFS_RQ_WD);
  wire wr_rq_d0 = wr && (addr == `CMR_OFS_RQ_DIAG0);
  wire wr_rq_d1 = wr && (addr == `CMR_OFS_RQ_DIAGNOSIS_1);
  // Status word: bit0 busy, bits 3:1 pending request groups
  wire [7:0] status_word = {4'h0, (|pend_d1_reg), (|pend_d0_reg),
                            (|pend_wd_reg), busy_reg};
  // Write-only registers read as zero; status sits at the command offset
  wire [7:0] rdata_next = (rd && addr == `CMR_OFS_CMD) ? status_word :
                          `CMR_RESET_VAL;

  // ------------------------------------------------------------
  // Command pulses and relay level
  // ------------------------------------------------------------
  // pulses, no storage
  wire [5:0] fire_vec = wr_cmd ? wdata[7:2] : 6'h00;
  wire [5:0] pulse_vec;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pulse
      cmr_pulse u_pulse (
        .clk(clk),
        .rst(rst),
        .fire(fire_vec[g]),
        .pulse(pulse_vec[g])
      );
    end
  endgenerate
  assign wake_signal_clear = pulse_vec[`CMR_B_WAKE_CLR-2];
  assign delayed_off_timer_restart = pulse_vec[`CMR_B_DOT_RST-2];
  assign engine_off_timer_start = pulse_vec[`CMR_B_EOT_START-2];
  assign upstream_stop = pulse_vec[`CMR_B_UP_STOP-2];
  assign heartbeat_timer_sample = pulse_vec[`CMR_B_HB_SAMPLE-2];
  assign sensor_diag_start = pulse_vec[`CMR_B_SENS_DIAG-2];

  wire relay_take = wr_cmd && wdata[`CMR_B_MR_EN];
  wire relay_next = relay_take ? wdata[`CMR_B_MR_ON] : relay_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relay_next;
    end
  end
  assign main_relay_state = relay_reg;

  // ------------------------------------------------------------
  // Request masks and burst sequencer
  // ------------------------------------------------------------

  // Group currently draining: 0 watchdog, 1 diag0, 2 diagnosis_1
  wire [7:0] cur_mask = (grp_reg == 2'd0) ? pend_wd_reg :
                        (grp_reg == 2'd1) ? pend_d0_reg : pend_d1_reg;
  wire [2:0] pick_idx;
  wire pick_any;
  cmr_pick #(.W(8)) u_pick (
    .mask(cur_mask),
    .idx(pick_idx),
    .any(pick_any)
  );
  wire [55:0] tgt_wd = `CMR_TGT_WD;
  wire [55:0] tgt_d0 = `CMR_TGT_DIAG0;
  wire [55:0] tgt_d1 = `CMR_TGT_DIAGNOSIS_1;
  wire [55:0] tgt_cur = (grp_reg == 2'd0) ? tgt_wd :
                        (grp_reg == 2'd1) ? tgt_d0 : tgt_d1;
  wire [6:0] tgt_addr = tgt_cur[pick_idx*7 +: 7];
  wire [7:0] one_hot = 8'h01 << pick_idx;
  wire [7:0] rest_mask = cur_mask & ~one_hot;
  wire accept = valid_reg && burst_ready;
  wire load_ok = (state_reg == CMR_IDLE);

  // Sequencer: new request writes are taken only while idle,
  // so a burst is never reshuffled mid-flight
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CMR_IDLE: begin
        if (pick_any) begin
          state_next = CMR_SEND;
        end else if (grp_reg != 2'd2) begin
          state_next = CMR_IDLE;
        end
      end
      CMR_SEND: begin
        state_next = CMR_WAIT;
      end
      CMR_WAIT: begin
        if (accept) begin
          state_next = CMR_IDLE;
        end
      end
      default: begin
        state_next = CMR_IDLE;
      end
    endcase
  end

  wire any_req = (pend_wd_reg != 8'h00) || (pend_d0_reg != 8'h00) ||
                 (pend_d1_reg != 8'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CMR_IDLE;
      grp_reg <= 2'd0;
      pend_wd_reg <= 8'h00;
      pend_d0_reg <= 8'h00;
      pend_d1_reg <= 8'h00;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
      baddr_reg <= 7'h00;
      busy_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      busy_reg <= any_req || valid_reg;
      if (load_ok && !pick_any) begin
        // Empty group: move on, wrap to watchdog group
        grp_reg <= (grp_reg == 2'd2) ? 2'd0 : grp_reg + 2'd1;
      end
      if (state_reg == CMR_SEND) begin
        valid_reg <= 1'b1;
        baddr_reg <= tgt_addr;
        last_reg <= (rest_mask == 8'h00) &&
                    !((grp_reg < 2'd1) && (pend_d0_reg != 8'h00)) &&
                    !((grp_reg < 2'd2) && (pend_d1_reg != 8'h00));
        // Retire the bit once it is handed out
        case (grp_reg)
          2'd0: pend_wd_reg <= rest_mask;
          2'd1: pend_d0_reg <= rest_mask;
          default: pend_d1_reg <= rest_mask;
        endcase
      end else if (accept) begin
        valid_reg <= 1'b0;
        last_reg <= 1'b0;
      end else if (load_ok && !any_req) begin
        if (wr_rq_wd) begin
          pend_wd_reg <= wdata;
        end
        if (wr_rq_d0) begin
          pend_d0_reg <= wdata;
        end
        if (wr_rq_d1) begin
          pend_d1_reg <= wdata;
        end
      end
    end
  end

  assign burst_valid = valid_reg;
  assign burst_addr = baddr_reg;
  assign burst_last = last_reg;
  assign burst_busy = busy_reg;
  assign rdata = rdata_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_WAKE: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[7]) |=> wake_signal_clear)
    else $error("wake clear pulse missing");
  AST_DOT: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[6]) |=> !delayed_off_timer_restart)
    else $error("spurious delayed-off restart");
  AST_EOT: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[5]) |=> engine_off_timer_start)
    else $error("engine-off start missing");
  AST_UPS: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[4]) |=> upstream_stop)
    else $error("upstream stop missing");
  AST_HB: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[3]) |=> heartbeat_timer_sample)
    else $error("heartbeat sample missing");
  AST_SDG: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[2]) |=> sensor_diag_start)
    else $error("sensor diag start missing");
  AST_RELAY: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[0])
      |=> main_relay_state == $past(wdata[1]))
    else $error("relay level not taken");
  AST_GATE: assert property (@(posedge clk) disable iff (rst)
    (!(wr && addr == `CMR_OFS_CMD && wdata[0]))
      |=> $stable(main_relay_state))
    else $error("relay changed without enable");
  AST_PULSE: assert property (@(posedge clk) disable iff (rst)
    wake_signal_clear |-> $past(wr && addr == `CMR_OFS_CMD &&
                                wdata[`CMR_B_WAKE_CLR]))
    else $error("wake pulse without write");
  // Zero bits must stay quiet; a set delayed-off restart bit must pulse
  AST_WAKE_NONE: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_WAKE_CLR])
      |=> !wake_signal_clear)
    else $error("spurious wake clear");
  AST_DOT_SET: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_DOT_RST])
      |=> delayed_off_timer_restart)
    else $error("delayed-off restart missing");
  AST_EOT_NONE: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_EOT_START])
      |=> !engine_off_timer_start)
    else $error("spurious engine-off start");
  AST_UPS_NONE: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_UP_STOP])
      |=> !upstream_stop)
    else $error("spurious upstream stop");
  AST_HB_NONE: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_HB_SAMPLE])
      |=> !heartbeat_timer_sample)
    else $error("spurious heartbeat sample");
  AST_SDG_NONE: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `CMR_OFS_CMD && wdata[`CMR_B_SENS_DIAG])
      |=> !sensor_diag_start)
    else $error("spurious sensor diag start");
  // A word on offer keeps the busy flag up
  AST_BUSY: assert property (@(posedge clk) disable iff (rst)
    burst_valid |=> burst_busy)
    else $error("busy low with word outstanding");
  AST_ZERO: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_RQ_WD && wdata == `CMR_RESET_VAL &&
     !burst_busy && !burst_valid) |=> !burst_valid)
    else $error("zero request started a burst");
  AST_RDATA: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == `CMR_RESET_VAL)
    else $error("read data without read strobe");
  AST_WD0: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_RQ_WD && wdata == 8'h01 && !burst_busy &&
     !burst_valid) |-> ##[1:12] (burst_valid && burst_addr == 7'h3a &&
     burst_last))
    else $error("watchdog bit 0 target wrong");
  AST_D07: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_RQ_DIAG0 && wdata == 8'h80 && !burst_busy &&
     !burst_valid) |-> ##[1:12] (burst_valid && burst_addr == 7'h2a))
    else $error("diagnosis bit 7 target wrong");
  AST_D17: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_RQ_DIAGNOSIS_1 && wdata == 8'h80 && !burst_busy &&
     !burst_valid) |-> ##[1:12] (burst_valid && burst_addr == 7'h2d))
    else $error("output diagnosis bit 7 target wrong");
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    (burst_valid && !burst_ready) |=> burst_valid && $stable(burst_addr))
    else $error("burst word dropped");
  AST_WD7: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `CMR_OFS_RQ_WD && wdata == 8'h80 && !burst_busy &&
     !burst_valid) |-> ##[1:12] (burst_valid && burst_addr == 7'h5f))
    else $error("watchdog bit 7 target wrong");
endmodule : cmr_regs

/* bench/cmr_link_sink.sv */
// Serial link model that takes multi-read burst words
`timescale 1ns/1ps
module cmr_link_sink (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset
  input wire logic slow, // Stall on some cycles
  input wire logic burst_valid, // Word offered
  output logic burst_ready // Word taken
);
  logic [2:0] cnt_reg;
  // Free-running stall pattern, so stalls land at awkward points
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  // Prompt link, or one that takes words only half the time
  assign burst_ready = !slow || (cnt_reg[2] && burst_valid);
endmodule : cmr_link_sink

/* bench/cmr_regs_tb_top.sv */
// Self-checking bench for the command and multi-read request block
`timescale 1ns/1ps
module cmr_regs_tb_top;
  logic clk, rst, wr, rd, slow, rex, tk, rk;
  logic [6:0] addr, ba;
  logic [7:0] wdata, rdata, m;
  logic wk, dot, eot, ups, hb, sd, relay, rdy, bv, bl, bb;
  int n_errors = 0;
  int n_checks = 0;
  integer seed = 32'hcaac;
  logic [7:0] q_cmd[$], q_rd[$], q_bst[$];
  // Target offsets per group, request bit 7 first
  logic [6:0] tg [24] = '{7'h5f, 7'h63, 7'h36, 7'h2e, 7'h38, 7'h37, 7'h39,
    7'h3a, 7'h2a, 7'h21, 7'h33, 7'h32, 7'h31, 7'h24, 7'h23, 7'h22, 7'h2d,
    7'h2c, 7'h2b, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25};
  logic [7:0] cl [12] = '{8'h02, 8'h03, 8'h02, 8'h01, 8'h00, 8'h80, 8'h40,
    8'h20, 8'h10, 8'h08, 8'h04, 8'hfc};

  cmr_regs cmr_regs_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wake_signal_clear(wk),
    .delayed_off_timer_restart(dot), .engine_off_timer_start(eot),
    .upstream_stop(ups), .heartbeat_timer_sample(hb),
    .sensor_diag_start(sd), .main_relay_state(relay), .burst_ready(rdy),
    .burst_valid(bv), .burst_addr(ba), .burst_last(bl), .burst_busy(bb));
  cmr_link_sink cmr_link_sink_inst (.clk(clk), .rst(rst), .slow(slow),
    .burst_valid(bv), .burst_ready(rdy));

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // Relay level follows bit 1 only when bit 0 is set
  task automatic cmd(input logic [7:0] d);
    if (d[0]) begin
      rex = d[1];
    end
    q_cmd.push_back({d[7:2], rex, 1'b0});
    wr_reg(7'h01, d);
  endtask : cmd
  // Expect requested targets MSB first, last flag on the lowest set bit
  task automatic req(input int g, input logic [7:0] d);
    for (int b = 7; b >= 0; b--) begin
      if (d[b]) begin
        q_bst.push_back({(d & ((8'h01 << b) - 8'h01)) == 8'h00,
          tg[g * 8 + 7 - b]});
      end
    end
    wr_reg(7'(3 + g), d);
  endtask : req
  task automatic wait_idle;
    int i;
    i = 0;
    // Busy rises two edges after the write; poll between edges
    repeat (2) @(posedge clk);
    @(negedge clk);
    while (bb && i < 400) begin
      @(negedge clk);
      i++;
    end
    if (i >= 400) begin
      n_errors++;
    end
    chk(8'(q_bst.size()), 8'h00);
  endtask : wait_idle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Output monitor, takes the oldest note per result
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst) begin
      if (tk) begin
        chk({wk, dot, eot, ups, hb, sd, relay, 1'b0}, q_cmd.pop_front());
      end else begin
        chk({wk, dot, eot, ups, hb, sd, 2'b00}, 8'h00);
      end
      if (rk) begin
        chk(rdata, q_rd.pop_front());
      end
      if (bv && rdy) begin
        chk({bl, ba}, q_bst.size() > 0 ? q_bst.pop_front() : 8'hff);
      end
    end
    tk = wr && addr == 7'h01 && !rst;
    rk = rd && !rst;
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog, well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    rex = 1'b0;
    tk = 1'b0;
    rk = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Every command bit, relay gating, then random words
    foreach (cl[i]) cmd(cl[i]);
    repeat (16) cmd(8'($random(seed)));
    $display("test commands done");
    // Full masks for each group, then random masks on a stalling link
    for (int g = 0; g < 3; g++) begin
      req(g, 8'hff);
      wait_idle();
    end
    slow <= 1'b1;
    repeat (9) begin
      m = 8'($random(seed));
      req(int'($unsigned($random(seed)) % 3), m);
      wait_idle();
    end
    // Single-bit requests at the group ends
    req(0, 8'h80);
    wait_idle();
    req(0, 8'h01);
    wait_idle();
    req(1, 8'h80);
    wait_idle();
    req(2, 8'h80);
    wait_idle();
    $display("test bursts done");
    // Write while busy is dropped; zero write starts nothing
    req(0, 8'h81);
    wr_reg(7'h05, 8'h10);
    wait_idle();
    wr_reg(7'h04, 8'h00);
    @(posedge clk);
    chk({7'h00, bb}, 8'h00);
    rd_reg(7'h01, 8'h00);
    rd_reg(7'h03, 8'h00);
    rd_reg(7'h7f, 8'h00);
    repeat (2) @(posedge clk);
    $display("test refusals and reads done");
    end_sim();
  end
endmodule : cmr_regs_tb_top
